// ### core/sgpc_cfg.svh
// Register offsets, field positions, reset values and timing for the port control block
`ifndef SGPC_CFG_SVH
`define SGPC_CFG_SVH

`define SGPC_OFF_IDVER 8'h00
`define SGPC_OFF_SOFT 8'h04
`define SGPC_OFF_CTRL 8'h10
`define SGPC_OFF_STAT 8'h14
`define SGPC_OFF_ADV 8'h18
`define SGPC_OFF_NPTX 8'h1c
`define SGPC_OFF_LPADV 8'h20
`define SGPC_OFF_LPNP 8'h24
`define SGPC_OFF_IRQ_STAT 8'h40
`define SGPC_OFF_IRQ_CLR 8'h44
`define SGPC_OFF_IRQ_EN 8'h48

`define SGPC_SOFT_ALL_BIT 0
`define SGPC_SOFT_PATH_BIT 1

`define SGPC_CTRL_AN_EN 0
`define SGPC_CTRL_AN_RESTART 1
`define SGPC_CTRL_SHORT_LT 2
`define SGPC_CTRL_NP_READY 3
`define SGPC_CTRL_LOOPBACK 4
`define SGPC_CTRL_MASTER 5
`define SGPC_CTRL_COMMA 6
`define SGPC_CTRL_WIDTH 7
`define SGPC_CTRL_RESET 7'h00

`define SGPC_ABIL_NEXT_PAGE 15
`define SGPC_ABIL_DUPLEX 12
`define SGPC_ABIL_SPEED_HI 11
`define SGPC_ABIL_SPEED_LO 10
`define SGPC_SPEED_GIG 2'h2

// Identity value is arbitrary; version fields are the documented reset values
`define SGPC_IDENT 16'h5a5a
`define SGPC_RTL_VER 5'h00
`define SGPC_MAJOR_VER 3'h1
`define SGPC_CUSTOM 2'h0
`define SGPC_MINOR_VER 6'h02

`define SGPC_K28_5 10'h0fa
`define SGPC_CLK_NS 10
`define SGPC_LT_FIBER_NS 10000000
`define SGPC_LT_SERIAL_NS 1600000
`define SGPC_LT_SHORT_NS 2000

`define SGPC_IRQ_COMPLETE 0
`define SGPC_IRQ_PAGE 1
`define SGPC_IRQ_ERROR 2
`define SGPC_IRQ_WIDTH 3

`endif

// ### core/sgpc_pkg.sv
// Types shared by the port control block
package sgpc_pkg;
    typedef enum logic [2:0] {
        SGPC_AN_IDLE,
        SGPC_AN_LINK_WAIT,
        SGPC_AN_ABILITY,
        SGPC_AN_NEXT_PAGE,
        SGPC_AN_NP_DONE,
        SGPC_AN_COMPLETE
    } sgpc_an_state_e;
    typedef logic [15:0] sgpc_page_t;
endpackage : sgpc_pkg

// ### core/sgpc_link_timer.sv
// Auto-negotiation link timer with three selectable lengths
module sgpc_link_timer
    import sgpc_pkg::*;
#(
    parameter int FIBER_CYC = 1000000,
    parameter int SERIAL_CYC = 160000,
    parameter int SHORT_CYC = 200
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic short_sel,
    input wire logic serial_mode,
    // Result
    output logic done
);
    localparam int CW = $clog2(FIBER_CYC + 1);

    logic [CW-1:0] count_reg;
    logic running_reg;
    logic [CW-1:0] load_value;

    always_comb
    begin
        if (short_sel)
            load_value = CW'(SHORT_CYC - 1);
        else if (serial_mode)
            load_value = CW'(SERIAL_CYC - 1);
        else
            load_value = CW'(FIBER_CYC - 1);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            count_reg <= '0;
            running_reg <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                count_reg <= load_value;
                running_reg <= 1'b1;
            end
            else if (running_reg)
            begin
                if (count_reg == '0)
                begin
                    running_reg <= 1'b0;
                    done <= 1'b1;
                end
                else
                    count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : sgpc_link_timer

// ### core/sgpc_port_control.sv
// Register map, resets, line controls and negotiation sequencing of one serial gigabit port
//
// Our own choice: the strobed register port.
`include "sgpc_cfg.svh"

// Operation
// - Writing one to reset bit 0 resets whole module; bit reads zero. Reset lands a cycle later; synchronisers, edge flops and read data are spared.
// - Reset bit 1 holds transmit/receive paths in reset until zero written.
// - Control bit 6 forces K28.5 continuously onto encoded transmit output.
// - Bit 5 master takes speed and duplex from local ability, else partner.
// - Bit 4 loopback clocks transmit and receive paths from transmit clock.
// - Writing bit 3 after loading next page tells negotiation it is ready.
// - Negotiation clears next-page-ready before setting page-received flag.
// - Next-page-ready is ignored while serial-gigabit mode input is high.
// - Registers decode at their fixed offsets; gaps are reserved.
// - Identity register packs identity, RTL, major, custom, minor fields.
// - Each instance owns an identical register set at its own base.
// - Bit 2 selects 2us link timer, else mode input picks 10ms fiber or 1.6ms serial.
// - Writing one then zero to bit 1 restarts negotiation.
// - Writing one to bit 0 enables negotiation.
// - Page-received flag set by negotiation, cleared by writing bit 3.
module sgpc_port_control
    import sgpc_pkg::*;
#(
    parameter logic [3:0] PORT_SEL = 4'h0,
    parameter int LT_FIBER_CYC = (`SGPC_LT_FIBER_NS + `SGPC_CLK_NS - 1) / `SGPC_CLK_NS,
    parameter int LT_SERIAL_CYC = (`SGPC_LT_SERIAL_NS + `SGPC_CLK_NS - 1) / `SGPC_CLK_NS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq,
    // Pins from outside the clock domain
    input wire logic tx_clk_pin,
    input wire logic rx_clk_pin,
    input wire logic serial_mode_pin,
    input wire logic lock_pin,
    input wire logic sig_detect_pin,
    input wire logic rx_page_valid_pin,
    input wire logic [15:0] rx_page_pin,
    // Transmit path
    input wire logic [9:0] tx_code_in,
    output logic [9:0] encoded_tx_output,
    output logic [15:0] tx_config_word,
    // Resolved link
    output logic [1:0] link_speed,
    output logic link_full_duplex,
    output logic link_up
);
    localparam int LT_SHORT_CYC = (`SGPC_LT_SHORT_NS + `SGPC_CLK_NS - 1) / `SGPC_CLK_NS;
    localparam int PIN_W = 22;

    function automatic logic hit(input logic [11:0] addr, input logic [7:0] off);
        hit = (addr[11:8] == PORT_SEL) && (addr[7:0] == off);
    endfunction : hit

    // Two-flop synchronisers on every pin
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    assign pin_raw = {rx_page_pin, rx_page_valid_pin, sig_detect_pin, lock_pin,
        serial_mode_pin, rx_clk_pin, tx_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++)
        begin : g_sync
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    logic tx_clk_s;
    logic rx_clk_s;
    logic serial_mode;
    logic lock_s;
    logic sig_detect_s;
    logic rx_valid_s;
    sgpc_page_t rx_page_s;
    assign tx_clk_s = pin_sync_reg[0];
    assign rx_clk_s = pin_sync_reg[1];
    assign serial_mode = pin_sync_reg[2];
    assign lock_s = pin_sync_reg[3];
    assign sig_detect_s = pin_sync_reg[4];
    assign rx_valid_s = pin_sync_reg[5];
    assign rx_page_s = pin_sync_reg[21:6];

    // Resets: one-cycle core reset pulse (not synchronisers, edge flops or read data) and held path reset
    logic soft_pulse_reg;
    logic core_rst;
    logic path_reset_reg;
    logic path_rst;
    assign core_rst = rst | soft_pulse_reg;
    assign path_rst = core_rst | path_reset_reg;

    logic soft_wr;
    logic ctrl_wr;
    assign soft_wr = reg_wr && hit(reg_addr, `SGPC_OFF_SOFT);
    assign ctrl_wr = reg_wr && hit(reg_addr, `SGPC_OFF_CTRL);

    always_ff @(posedge clock)
    begin
        if (rst)
            soft_pulse_reg <= 1'b0;
        else
            soft_pulse_reg <= soft_wr && reg_wdata[`SGPC_SOFT_ALL_BIT];
    end

    always_ff @(posedge clock)
    begin
        if (core_rst)
            path_reset_reg <= 1'b0;
        else if (soft_wr)
            path_reset_reg <= reg_wdata[`SGPC_SOFT_PATH_BIT];
    end

    // Control register
    logic [`SGPC_CTRL_WIDTH-1:0] ctrl_reg;
    logic np_clear;
    logic np_ready;
    assign np_ready = ctrl_reg[`SGPC_CTRL_NP_READY] && !serial_mode;

    always_ff @(posedge clock)
    begin
        if (core_rst)
            ctrl_reg <= `SGPC_CTRL_RESET;
        else if (ctrl_wr)
            ctrl_reg <= reg_wdata[`SGPC_CTRL_WIDTH-1:0];
        else if (np_clear)
            ctrl_reg[`SGPC_CTRL_NP_READY] <= 1'b0;
    end

    sgpc_page_t adv_reg;
    sgpc_page_t nptx_reg;
    always_ff @(posedge clock)
    begin
        if (core_rst)
        begin
            adv_reg <= '0;
            nptx_reg <= '0;
        end
        else
        begin
            if (reg_wr && hit(reg_addr, `SGPC_OFF_ADV))
                adv_reg <= reg_wdata[15:0];
            if (reg_wr && hit(reg_addr, `SGPC_OFF_NPTX))
                nptx_reg <= reg_wdata[15:0];
        end
    end

    // Link-side edges; loopback runs receive from the transmit clock
    logic tx_clk_d_reg;
    logic rx_clk_d_reg;
    logic tx_edge;
    logic link_edge;
    logic loopback;
    assign loopback = ctrl_reg[`SGPC_CTRL_LOOPBACK];

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_clk_d_reg <= 1'b0;
            rx_clk_d_reg <= 1'b0;
        end
        else
        begin
            tx_clk_d_reg <= tx_clk_s;
            rx_clk_d_reg <= rx_clk_s;
        end
    end
    assign tx_edge = tx_clk_s && !tx_clk_d_reg;
    assign link_edge = loopback ? tx_edge : (rx_clk_s && !rx_clk_d_reg);

    // Transmit path
    always_ff @(posedge clock)
    begin
        if (path_rst)
            encoded_tx_output <= '0;
        else if (tx_edge)
            encoded_tx_output <= ctrl_reg[`SGPC_CTRL_COMMA] ? `SGPC_K28_5 : tx_code_in;
    end

    // Receive path: pages captured on the link edge
    logic rx_got_reg;
    sgpc_page_t rx_word_reg;
    always_ff @(posedge clock)
    begin
        if (path_rst)
        begin
            rx_got_reg <= 1'b0;
            rx_word_reg <= '0;
        end
        else
        begin
            rx_got_reg <= link_edge && (loopback || rx_valid_s);
            if (link_edge)
                rx_word_reg <= loopback ? tx_config_word : rx_page_s;
        end
    end

    // Negotiation sequencer
    sgpc_an_state_e an_state_reg;
    logic lt_start;
    logic lt_done;
    logic an_hold;
    sgpc_page_t lp_adv_reg;
    sgpc_page_t lp_np_reg;
    logic np_flag_reg;
    logic an_complete;
    logic page_event;
    assign an_hold = !ctrl_reg[`SGPC_CTRL_AN_EN] || ctrl_reg[`SGPC_CTRL_AN_RESTART]
        || path_reset_reg;
    assign lt_start = (an_state_reg == SGPC_AN_IDLE) && !an_hold;
    assign np_clear = (an_state_reg == SGPC_AN_NEXT_PAGE) && np_ready && rx_got_reg;
    assign page_event = an_state_reg == SGPC_AN_NP_DONE;
    assign an_complete = an_state_reg == SGPC_AN_COMPLETE;

    sgpc_link_timer #(
        .FIBER_CYC(LT_FIBER_CYC),
        .SERIAL_CYC(LT_SERIAL_CYC),
        .SHORT_CYC(LT_SHORT_CYC)
    ) u_link_timer (
        .clock(clock),
        .rst(core_rst),
        .start(lt_start),
        .short_sel(ctrl_reg[`SGPC_CTRL_SHORT_LT]),
        .serial_mode(serial_mode),
        .done(lt_done)
    );

    always_ff @(posedge clock)
    begin
        if (core_rst || an_hold)
            an_state_reg <= SGPC_AN_IDLE;
        else
        begin
            case (an_state_reg)
                SGPC_AN_IDLE:
                    an_state_reg <= SGPC_AN_LINK_WAIT;
                SGPC_AN_LINK_WAIT:
                    if (lt_done)
                        an_state_reg <= SGPC_AN_ABILITY;
                SGPC_AN_ABILITY:
                    if (rx_got_reg)
                    begin
                        // Next pages exist only outside serial-gigabit mode
                        if (adv_reg[`SGPC_ABIL_NEXT_PAGE] && !serial_mode)
                            an_state_reg <= SGPC_AN_NEXT_PAGE;
                        else
                            an_state_reg <= SGPC_AN_COMPLETE;
                    end
                SGPC_AN_NEXT_PAGE:
                    if (np_clear)
                        an_state_reg <= SGPC_AN_NP_DONE;
                SGPC_AN_NP_DONE:
                    an_state_reg <= SGPC_AN_COMPLETE;
                SGPC_AN_COMPLETE:
                    an_state_reg <= SGPC_AN_COMPLETE;
                default:
                    an_state_reg <= SGPC_AN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (core_rst)
        begin
            lp_adv_reg <= '0;
            lp_np_reg <= '0;
        end
        else
        begin
            if (an_state_reg == SGPC_AN_ABILITY && rx_got_reg)
                lp_adv_reg <= rx_word_reg;
            if (np_clear)
                lp_np_reg <= rx_word_reg;
        end
    end

    // Flag set one cycle after the ready bit is cleared; set beats clear
    always_ff @(posedge clock)
    begin
        if (core_rst)
            np_flag_reg <= 1'b0;
        else if (page_event)
            np_flag_reg <= 1'b1;
        else if (ctrl_wr && reg_wdata[`SGPC_CTRL_NP_READY])
            np_flag_reg <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (path_rst)
            tx_config_word <= '0;
        else if (an_state_reg == SGPC_AN_NEXT_PAGE || an_state_reg == SGPC_AN_NP_DONE)
            tx_config_word <= nptx_reg;
        else
            tx_config_word <= adv_reg;
    end

    // Speed and duplex resolution
    sgpc_page_t resolve_src;
    logic an_error;
    assign resolve_src = ctrl_reg[`SGPC_CTRL_MASTER] ? adv_reg : lp_adv_reg;
    assign an_error = an_complete && serial_mode && !resolve_src[`SGPC_ABIL_DUPLEX]
        && resolve_src[`SGPC_ABIL_SPEED_HI:`SGPC_ABIL_SPEED_LO] == `SGPC_SPEED_GIG;

    always_ff @(posedge clock)
    begin
        if (core_rst)
        begin
            link_speed <= '0;
            link_full_duplex <= 1'b0;
            link_up <= 1'b0;
        end
        else
        begin
            link_speed <= resolve_src[`SGPC_ABIL_SPEED_HI:`SGPC_ABIL_SPEED_LO];
            link_full_duplex <= resolve_src[`SGPC_ABIL_DUPLEX];
            link_up <= an_complete && lock_s && !an_error;
        end
    end

    // Interrupt status, enable and clear
    logic [`SGPC_IRQ_WIDTH-1:0] irq_stat_reg;
    logic [`SGPC_IRQ_WIDTH-1:0] irq_en_reg;
    logic [`SGPC_IRQ_WIDTH-1:0] irq_set;
    logic [`SGPC_IRQ_WIDTH-1:0] irq_clr;
    logic complete_d_reg;
    logic error_d_reg;
    assign irq_set = {an_error && !error_d_reg, page_event, an_complete && !complete_d_reg};
    assign irq_clr = (reg_wr && hit(reg_addr, `SGPC_OFF_IRQ_CLR)) ?
        reg_wdata[`SGPC_IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge clock)
    begin
        if (core_rst)
        begin
            irq_stat_reg <= '0;
            irq_en_reg <= '0;
            complete_d_reg <= 1'b0;
            error_d_reg <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            complete_d_reg <= an_complete;
            error_d_reg <= an_error;
            // Set wins so an event on the clearing write is kept
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            if (reg_wr && hit(reg_addr, `SGPC_OFF_IRQ_EN))
                irq_en_reg <= reg_wdata[`SGPC_IRQ_WIDTH-1:0];
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Read path, one cycle latency; unmapped offsets read zero
    logic [31:0] rd_value;
    always_comb
    begin
        rd_value = '0;
        if (reg_addr[11:8] == PORT_SEL)
        begin
            case (reg_addr[7:0])
                `SGPC_OFF_IDVER:
                    rd_value = {`SGPC_IDENT, `SGPC_RTL_VER, `SGPC_MAJOR_VER,
                        `SGPC_CUSTOM, `SGPC_MINOR_VER};
                `SGPC_OFF_SOFT:
                    rd_value = {30'h0, path_reset_reg, 1'b0};
                `SGPC_OFF_CTRL:
                    rd_value = {25'h0, ctrl_reg};
                `SGPC_OFF_STAT:
                    rd_value = {26'h0, sig_detect_s, lock_s, np_flag_reg, an_complete,
                        an_error, link_up};
                `SGPC_OFF_ADV:
                    rd_value = {16'h0, adv_reg};
                `SGPC_OFF_NPTX:
                    rd_value = {16'h0, nptx_reg};
                `SGPC_OFF_LPADV:
                    rd_value = {16'h0, lp_adv_reg};
                `SGPC_OFF_LPNP:
                    rd_value = {16'h0, lp_np_reg};
                `SGPC_OFF_IRQ_STAT:
                    rd_value = {29'h0, irq_stat_reg};
                `SGPC_OFF_IRQ_EN:
                    rd_value = {29'h0, irq_en_reg};
                default:
                    rd_value = '0;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rd_value;
        else
            reg_rdata <= '0;
    end
endmodule : sgpc_port_control

// ### tb/sgpc_port_control_sva.sv
// Port-level assertions for the port control block
`include "sgpc_cfg.svh"
module sgpc_port_control_sva
    import sgpc_pkg::*;
#(
    parameter logic [3:0] PORT_SEL = 4'h0
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Outputs
    input wire logic irq,
    input wire logic [9:0] encoded_tx_output,
    input wire logic [1:0] link_speed,
    input wire logic link_full_duplex,
    input wire logic link_up
);
    logic [5:0] calm_reg;
    logic [6:0] ctrl_reg;
    logic [15:0] adv_reg;
    logic path_reg;
    logic rd_q_reg;
    logic [7:0] off_q_reg;
    wire logic wr_sel = reg_wr && reg_addr[11:8] == PORT_SEL;
    wire logic soft_all = wr_sel && reg_addr[7:0] == `SGPC_OFF_SOFT && reg_wdata[0];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    always_ff @(posedge clock)
    begin
        if (rst || wr_sel)
            calm_reg <= 6'h00;
        else if (calm_reg != 6'h3f)
            calm_reg <= calm_reg + 6'h01;
    end
    always_ff @(posedge clock)
    begin
        if (rst || soft_all)
        begin
            ctrl_reg <= 7'h00;
            adv_reg <= 16'h0000;
            path_reg <= 1'b0;
        end
        else if (wr_sel && reg_addr[7:0] == `SGPC_OFF_CTRL)
            ctrl_reg <= reg_wdata[6:0];
        else if (wr_sel && reg_addr[7:0] == `SGPC_OFF_ADV)
            adv_reg <= reg_wdata[15:0];
        else if (wr_sel && reg_addr[7:0] == `SGPC_OFF_SOFT)
            path_reg <= reg_wdata[1];
    end
    always_ff @(posedge clock)
    begin
        rd_q_reg <= reg_rd && reg_addr[11:8] == PORT_SEL;
        off_q_reg <= reg_addr[7:0];
    end
    a_rdata_quiet: assert property (
        !rd_q_reg |-> reg_rdata == 32'h0) else $error("read data outside its answer cycle");
    a_ident_word: assert property (
        rd_q_reg && off_q_reg == `SGPC_OFF_IDVER |-> reg_rdata == {`SGPC_IDENT,
        `SGPC_RTL_VER, `SGPC_MAJOR_VER, `SGPC_CUSTOM, `SGPC_MINOR_VER})
        else $error("identity word wrong");
    a_soft_readback: assert property (
        rd_q_reg && off_q_reg == `SGPC_OFF_SOFT |-> reg_rdata == {30'h0, path_reg, 1'b0})
        else $error("soft reset register readback wrong");
    a_comma_force: assert property (
        ctrl_reg[6] && !path_reg && calm_reg >= 6'd30 |-> encoded_tx_output == `SGPC_K28_5)
        else $error("comma pattern not on the line");
    a_path_hold: assert property (
        path_reg && calm_reg >= 6'd4 |-> encoded_tx_output == 10'h000 && !link_up)
        else $error("path reset not holding");
    a_master_source: assert property (
        ctrl_reg[5] && calm_reg >= 6'd4 |-> link_speed == adv_reg[11:10]
        && link_full_duplex == adv_reg[12]) else $error("master not using local ability");
    a_idle_no_link: assert property (
        (ctrl_reg[1] || !ctrl_reg[0]) && calm_reg >= 6'd4 |-> !link_up)
        else $error("link up while negotiation held");
    a_reset_quiet: assert property (
        $past(rst) |-> reg_rdata == 32'h0 && !irq && encoded_tx_output == 10'h000 && !link_up)
        else $error("outputs not quiet after reset");
    a_soft_clears: assert property (
        soft_all |-> ##3 (!link_up && !irq)) else $error("soft reset left state behind");
endmodule : sgpc_port_control_sva

bind sgpc_port_control sgpc_port_control_sva #(.PORT_SEL(PORT_SEL)) u_sva (.*);

// ### tb/sgpc_link_partner.sv
// Far-end model: link clocks, lock and the partner's configuration pages
module sgpc_link_partner
(
    // Control from the bench
    input wire logic page_on,
    input wire logic [15:0] page_word,
    input wire logic lock_on,
    // Pins toward the port
    output logic tx_clk_pin,
    output logic rx_clk_pin,
    output logic lock_pin,
    output logic sig_detect_pin,
    output logic rx_page_valid_pin,
    output logic [15:0] rx_page_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    assign lock_pin = lock_on;
    assign sig_detect_pin = lock_on;
    initial
    begin
        tx_clk_pin = 1'b0;
        #3.3;
        forever #62.5 tx_clk_pin = ~tx_clk_pin;
    end
    // Receive clock stands still between pages; page changes only while it is low
    initial
    begin
        rx_clk_pin = 1'b0;
        rx_page_valid_pin = 1'b0;
        rx_page_pin = 16'h0000;
        #41.7;
        forever
        begin
            #62.5;
            rx_clk_pin = page_on ? ~rx_clk_pin : 1'b0;
            rx_page_valid_pin = page_on;
            rx_page_pin = page_on ? page_word : ~rx_page_pin;
        end
    end
endmodule : sgpc_link_partner

// ### tb/test_sgpc_port_control.sv
// Self-checking bench for the port control block
`include "sgpc_cfg.svh"
module test_sgpc_port_control
    import sgpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] PSEL = 4'h3;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic serial_mode_pin = 1'b0;
    logic [9:0] tx_code_in = 10'h000;
    logic [31:0] reg_rdata, d;
    logic irq, tx_clk_pin, rx_clk_pin, lock_pin, sig_detect_pin, rx_page_valid_pin;
    logic [15:0] rx_page_pin, tx_config_word;
    logic [9:0] encoded_tx_output;
    logic [1:0] link_speed;
    logic link_full_duplex, link_up;
    logic page_on = 1'b0;
    logic hold = 1'b0;
    logic [15:0] page_word = 16'hd401;
    logic [31:0] seed = 32'd47581;
    logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40, 8'h48};
    logic [7:0] rsv [6] = '{8'h08, 8'h0c, 8'h28, 8'h3c, 8'h4c, 8'hfc};
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    always #5 clock = ~clock;
    sgpc_port_control #(.PORT_SEL(PSEL), .LT_FIBER_CYC(300), .LT_SERIAL_CYC(100)) dut (.*);
    sgpc_link_partner phy (.lock_on(1'b1), .*);
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] ident_word();
        return {`SGPC_IDENT, `SGPC_RTL_VER, `SGPC_MAJOR_VER, `SGPC_CUSTOM, `SGPC_MINOR_VER};
    endfunction : ident_word
    always @(posedge clock)
        if (!hold)
            tx_code_in <= 10'(xs());
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] off, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= {PSEL, off};
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic rchk(input logic [7:0] off, input logic [31:0] e);
        logic [31:0] v;
        rd({PSEL, off}, v);
        chk($sformatf("reg %h", off), e, v);
    endtask : rchk
    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : settle
    // Counts cycles until link reaches the level, then checks the span
    task automatic wait_link(input logic lvl, input int lo, input int hi);
        n = 0;
        #1;
        while (link_up !== lvl && n < 2000)
        begin
            settle(1);
            n++;
        end
        chk("link span", 1'b1, link_up === lvl && n >= lo && n <= hi);
    endtask : wait_link
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    initial
    begin
        #200000;
        bad_count++;
        final_report();
    end
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++)
            rchk(offs[i], (i == 0) ? ident_word() : 32'h0);
        rchk(8'h14, 32'h30);
        for (int i = 0; i < 6; i++)
        begin
            wr(rsv[i], 32'hffffffff);
            rchk(rsv[i], 32'h0);
        end
        wr(8'h00, 32'hffffffff);
        rchk(8'h00, ident_word());
        rd({PSEL + 4'h1, 8'h10}, d);
        chk("other port", 32'h0, d);
        for (int i = 0; i < 8; i++)
        begin
            d = xs();
            wr(8'h18, d);
            wr(8'h10, d & 32'hfffffffe);
            rchk(8'h18, {16'h0, d[15:0]});
            rchk(8'h10, d & 32'h7e);
        end
        hold <= 1'b1;
        wr(8'h10, 32'h40);
        settle(30);
        chk("comma", `SGPC_K28_5, encoded_tx_output);
        wr(8'h10, 32'h0);
        settle(30);
        chk("normal", tx_code_in, encoded_tx_output);
        wr(8'h04, 32'h2);
        rchk(8'h04, 32'h2);
        settle(30);
        chk("path held", 10'h000, encoded_tx_output);
        wr(8'h04, 32'h0);
        settle(30);
        chk("path free", tx_code_in, encoded_tx_output);
        hold <= 1'b0;
        wr(8'h18, 32'h1800);
        wr(8'h10, 32'h20);
        settle(4);
        chk("master", 3'b110, {link_full_duplex, link_speed});
        page_on <= 1'b1;
        wr(8'h48, 32'h7);
        wr(8'h10, 32'h5);
        wait_link(1'b1, 200, 260);
        rchk(8'h20, 32'hd401);
        chk("slave", 3'b101, {link_full_duplex, link_speed});
        rchk(8'h14, 32'h35);
        chk("irq raised", 1'b1, irq);
        wr(8'h44, 32'h7);
        rchk(8'h40, 32'h0);
        chk("irq cleared", 1'b0, irq);
        wr(8'h48, 32'h0);
        wr(8'h10, 32'h7);
        wait_link(1'b0, 0, 6);
        wr(8'h10, 32'h1);
        wait_link(1'b1, 300, 360);
        rchk(8'h40, 32'h1);
        chk("irq masked", 1'b0, irq);
        wr(8'h48, 32'h1);
        settle(2);
        chk("irq enabled", 1'b1, irq);
        wr(8'h44, 32'h1);
        wr(8'h10, 32'h0);
        wr(8'h18, 32'h9801);
        wr(8'h1c, 32'h2345);
        wr(8'h10, 32'hd);
        d = 32'h0;
        for (int i = 0; i < 400 && d[3] !== 1'b1; i++)
            rd({PSEL, 8'h14}, d);
        chk("page flag", 1'b1, d[3]);
        rd({PSEL, 8'h10}, d);
        chk("ready cleared", 1'b0, d[3]);
        rchk(8'h24, 32'hd401);
        rd({PSEL, 8'h40}, d);
        chk("page event", 1'b1, d[1]);
        wr(8'h10, 32'hd);
        rd({PSEL, 8'h14}, d);
        chk("flag cleared", 1'b0, d[3]);
        wr(8'h10, 32'h0);
        @(posedge clock);
        serial_mode_pin <= 1'b1;
        wr(8'h10, 32'h9);
        wait_link(1'b1, 100, 160);
        rchk(8'h14, 32'h35);
        wr(8'h04, 32'h1);
        settle(2);
        rchk(8'h04, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h18, 32'h0);
        chk("link after reset", 1'b0, link_up);
        @(posedge clock);
        serial_mode_pin <= 1'b0;
        page_on <= 1'b0;
        wr(8'h04, 32'h2);
        wr(8'h18, 32'h1401);
        wr(8'h10, 32'h15);
        wr(8'h04, 32'h0);
        wait_link(1'b1, 200, 260);
        rchk(8'h20, 32'h1401);
        chk("config word", 32'h1401, tx_config_word);
        final_report();
    end
endmodule : test_sgpc_port_control
